// >>> logic/ecc_map.svh
// Register offsets, field positions, reset values and codes
// Assumes inclusion by its bare name from the canceller bank files
`ifndef ECC_MAP_SVH
`define ECC_MAP_SVH

// Register offsets
`define ECC_OFS_CTRL_A 8'h01
`define ECC_OFS_STAT_A 8'h02
`define ECC_OFS_CTRL_B 8'h21
`define ECC_OFS_STAT_B 8'h22
`define ECC_CHAN_STRIDE 8'h20

// Feature control fields
`define ECC_CTL_TONE_OFF 7
`define ECC_CTL_PHASE_IGN 6
`define ECC_CTL_NLP_OFF 5
`define ECC_CTL_AUTO_BYP 4
`define ECC_CTL_NB_OFF 3
`define ECC_CTL_DCF_OFF 2
`define ECC_CTL_SEND_MUTE 1
`define ECC_CTL_RECV_MUTE 0

// Detector status fields
`define ECC_STS_TONE 6
`define ECC_STS_DTALK 5
`define ECC_STS_GATED 1
`define ECC_STS_NBAND 0

// Reset values and codes
`define ECC_CTRL_RST 8'h00
`define ECC_STAT_RST 8'h00
`define ECC_QUIET_CODE 8'hFF

`endif

// >>> logic/ecc_pkg.sv
// Types for the echo canceller control and status bank
// Assumes nothing beyond a SystemVerilog compiler
package ecc_pkg;

    // State of one canceller register pair
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] stat;
    } ecc_chan_st_t;

    // State of the bank: read port and output samples
    typedef struct packed {
        logic [7:0] rd_data;
        logic rd_valid;
        logic [1:0][7:0] far_out;
        logic [1:0][7:0] near_out;
    } ecc_top_st_t;

endpackage

// >>> logic/ecc_chan_if.sv
// Link between the bank decoder and one canceller register pair
// Assumes both ends run on the same reference clock
interface ecc_chan_if;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic tone_seen;
    logic phase_rev_seen;
    logic dtalk_seen;
    logic nband_seen;

    modport bank (
        output wr,
        output wdata,
        output tone_seen,
        output phase_rev_seen,
        output dtalk_seen,
        output nband_seen,
        input ctrl,
        input stat
    );

    modport chan (
        input wr,
        input wdata,
        input tone_seen,
        input phase_rev_seen,
        input dtalk_seen,
        input nband_seen,
        output ctrl,
        output stat
    );
endinterface

// >>> logic/ecc_chan.sv
// Feature control and detector status pair of one canceller
// Assumes detector inputs are synchronous to i_ref_clk
`include "ecc_map.svh"

module ecc_chan (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Bank side
    ecc_chan_if.chan ch
);
    ecc_pkg::ecc_chan_st_t st_q;
    ecc_pkg::ecc_chan_st_t st_d;
    logic tone_hit;

    always_comb begin
        st_d = st_q;
        // Qualified tone only while detection runs
        tone_hit = ch.tone_seen
            & ~st_q.ctrl[`ECC_CTL_TONE_OFF]
            & (st_q.ctrl[`ECC_CTL_PHASE_IGN]
               | ch.phase_rev_seen);
        if (ch.wr) begin
            st_d.ctrl = ch.wdata;
        end
        // Status rebuilt every cycle; writes never reach it
        st_d.stat = `ECC_STAT_RST;
        st_d.stat[`ECC_STS_TONE] = tone_hit;
        st_d.stat[`ECC_STS_DTALK] = ch.dtalk_seen;
        st_d.stat[`ECC_STS_GATED] =
            st_q.ctrl[`ECC_CTL_AUTO_BYP] & tone_hit;
        st_d.stat[`ECC_STS_NBAND] = ch.nband_seen
            & ~st_q.ctrl[`ECC_CTL_NB_OFF];
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_q.ctrl <= `ECC_CTRL_RST;
            st_q.stat <= `ECC_STAT_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign ch.ctrl = st_q.ctrl;
    assign ch.stat = st_q.stat;
endmodule // ecc_chan

// >>> logic/ecc_bank.sv
// Control and status bank for one group of two echo cancellers
// Assumes the host port and detectors are synchronous to i_ref_clk
`include "ecc_map.svh"

// Operation
// - Tone detection off bit stops that canceller's tone detection.
// - Both cancellers' tone detection off powers down group tone processors.
// - Phase ignore bit lets tone detectors trigger on plain 2100Hz tone.
// - Phase ignore cleared requires periodic phase reversals for triggering.
// - Nonlinear processor off bit disables the nonlinear processor.
// - Auto bypass with qualified tone switches the canceller into bypass.
// - Auto bypass cleared keeps echo cancellation running regardless of tone.
// - Narrow band detect off bit disables the narrow band detector.
// - DC filter off bit bypasses DC removal on both input paths.
// - Send mute replaces near end output with quiet code.
// - Receive mute replaces far end output with quiet code.
// - Tone flag is high while a qualified 2100Hz tone is present.
// - Double talk flag is high while double talk is detected.
// - Gated tone flag is auto bypass AND detected tone.
// - Bypass passes inputs straight through, zeroes coefficients, halts adapt.
module ecc_bank #(
    parameter int N_CHAN = 2,
    parameter logic [7:0] QUIET_CODE = `ECC_QUIET_CODE
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Host register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    // Detector reports, one bit per canceller
    input wire logic [N_CHAN-1:0] i_tone_seen,
    input wire logic [N_CHAN-1:0] i_phase_rev_seen,
    input wire logic [N_CHAN-1:0] i_dtalk_seen,
    input wire logic [N_CHAN-1:0] i_nband_seen,
    // PCM inputs and canceller core results
    input wire logic [N_CHAN-1:0][7:0] i_far_end_in,
    input wire logic [N_CHAN-1:0][7:0] i_near_end_in,
    input wire logic [N_CHAN-1:0][7:0] i_far_end_core,
    input wire logic [N_CHAN-1:0][7:0] i_near_end_core,
    // PCM outputs
    output logic [N_CHAN-1:0][7:0] o_far_end_out,
    output logic [N_CHAN-1:0][7:0] o_near_end_out,
    // Controls to the processing core
    output logic [N_CHAN-1:0] o_tone_det_en,
    output logic o_tone_pwr_down,
    output logic [N_CHAN-1:0] o_phase_rev_need,
    output logic [N_CHAN-1:0] o_nlp_en,
    output logic [N_CHAN-1:0] o_nband_det_en,
    output logic [N_CHAN-1:0] o_dc_filter_en,
    output logic [N_CHAN-1:0] o_bypass,
    output logic [N_CHAN-1:0] o_coef_clear,
    output logic [N_CHAN-1:0] o_adapt_halt
);
    ecc_pkg::ecc_top_st_t st_q;
    ecc_pkg::ecc_top_st_t st_d;
    logic [N_CHAN-1:0][7:0] ctrl;
    logic [N_CHAN-1:0][7:0] stat;
    logic [N_CHAN-1:0] hit_ctrl;
    logic [N_CHAN-1:0] hit_stat;
    logic [N_CHAN-1:0] byp;

    ecc_chan_if ch_if[N_CHAN]();

    // Register pairs, one per canceller
    for (genvar g = 0; g < N_CHAN; g++) begin : g_chan
        localparam logic [7:0] BASE = 8'(g * `ECC_CHAN_STRIDE);

        assign hit_ctrl[g] = (i_addr == (`ECC_OFS_CTRL_A + BASE));
        assign hit_stat[g] = (i_addr == (`ECC_OFS_STAT_A + BASE));

        assign ch_if[g].wr = i_wr_en & hit_ctrl[g];
        assign ch_if[g].wdata = i_wr_data;
        assign ch_if[g].tone_seen = i_tone_seen[g];
        assign ch_if[g].phase_rev_seen = i_phase_rev_seen[g];
        assign ch_if[g].dtalk_seen = i_dtalk_seen[g];
        assign ch_if[g].nband_seen = i_nband_seen[g];
        assign ctrl[g] = ch_if[g].ctrl;
        assign stat[g] = ch_if[g].stat;

        ecc_chan u_chan (
            .i_ref_clk(i_ref_clk),
            .i_sys_rst(i_sys_rst),
            .ch(ch_if[g])
        );
    end

    // Bypass follows the registered gated tone flag
    always_comb begin
        for (int i = 0; i < N_CHAN; i++) begin
            byp[i] = stat[i][`ECC_STS_GATED];
        end
    end

    // Next state: read port and output samples
    always_comb begin
        st_d = st_q;
        st_d.rd_valid = i_rd_en;
        if (i_rd_en) begin
            st_d.rd_data = 8'h00;
            for (int i = 0; i < N_CHAN; i++) begin
                if (hit_ctrl[i]) begin
                    st_d.rd_data = ctrl[i];
                end
                if (hit_stat[i]) begin
                    st_d.rd_data = stat[i];
                end
            end
        end
        for (int i = 0; i < N_CHAN; i++) begin
            // Core result unless bypassed
            if (byp[i]) begin
                st_d.far_out[i] = i_far_end_in[i];
                st_d.near_out[i] = i_near_end_in[i];
            end else begin
                st_d.far_out[i] = i_far_end_core[i];
                st_d.near_out[i] = i_near_end_core[i];
            end
            // Mute overrides every other source
            if (ctrl[i][`ECC_CTL_RECV_MUTE]) begin
                st_d.far_out[i] = QUIET_CODE;
            end
            if (ctrl[i][`ECC_CTL_SEND_MUTE]) begin
                st_d.near_out[i] = QUIET_CODE;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_q.rd_data <= 8'h00;
            st_q.rd_valid <= 1'b0;
            st_q.far_out <= {N_CHAN{QUIET_CODE}};
            st_q.near_out <= {N_CHAN{QUIET_CODE}};
        end else begin
            st_q <= st_d;
        end
    end

    // Core enables straight from the control bits; bypass, coef clear and adapt halt from the gated tone flag
    always_comb begin
        o_tone_pwr_down = 1'b1;
        for (int i = 0; i < N_CHAN; i++) begin
            o_tone_pwr_down = o_tone_pwr_down
                & ctrl[i][`ECC_CTL_TONE_OFF];
            o_tone_det_en[i] = ~ctrl[i][`ECC_CTL_TONE_OFF];
            o_phase_rev_need[i] =
                ~ctrl[i][`ECC_CTL_PHASE_IGN];
            o_nlp_en[i] = ~ctrl[i][`ECC_CTL_NLP_OFF];
            o_nband_det_en[i] = ~ctrl[i][`ECC_CTL_NB_OFF];
            o_dc_filter_en[i] = ~ctrl[i][`ECC_CTL_DCF_OFF];
            o_bypass[i] = byp[i];
            o_coef_clear[i] = byp[i];
            o_adapt_halt[i] = byp[i];
        end
    end

    assign o_rd_data = st_q.rd_data;
    assign o_rd_valid = st_q.rd_valid;
    assign o_far_end_out = st_q.far_out;
    assign o_near_end_out = st_q.near_out;
endmodule // ecc_bank

// >>> dv/ecc_bank_asserts.sv
// Concurrent checks on the control and status bank ports
// Assumes a single reference clock and a synchronous high reset
module ecc_bank_asserts #(
    parameter int N_CHAN = 2
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Host register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] o_rd_data,
    input wire logic o_rd_valid,
    // Core controls
    input wire logic [N_CHAN-1:0] o_tone_det_en,
    input wire logic o_tone_pwr_down,
    input wire logic [N_CHAN-1:0] o_phase_rev_need,
    input wire logic [N_CHAN-1:0] o_nlp_en,
    input wire logic [N_CHAN-1:0] o_nband_det_en,
    input wire logic [N_CHAN-1:0] o_dc_filter_en,
    input wire logic [N_CHAN-1:0] o_bypass,
    input wire logic [N_CHAN-1:0] o_coef_clear,
    input wire logic [N_CHAN-1:0] o_adapt_halt
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    logic wa;
    logic wb;
    assign wa = i_wr_en && i_addr == 8'h01;
    assign wb = i_wr_en && i_addr == 8'h21;
    a_pwr_down_and: assert property (
        o_tone_pwr_down == ~|o_tone_det_en) else $error("power down");
    a_bypass_ties: assert property (
        o_coef_clear == o_bypass && o_adapt_halt == o_bypass)
        else $error("bypass ties");
    a_tone_en: assert property (
        wa |=> o_tone_det_en[0] == !$past(i_wr_data[7])) else $error("tone");
    a_phase_need: assert property (
        wb |=> o_phase_rev_need[1] == !$past(i_wr_data[6])) else $error("ph");
    a_nlp_en: assert property (
        wb |=> o_nlp_en[1] == !$past(i_wr_data[5])) else $error("nlp");
    a_nband_en: assert property (
        wa |=> o_nband_det_en[0] == !$past(i_wr_data[3])) else $error("nb");
    a_dc_filter: assert property (
        wa ##1 !wa |=> o_dc_filter_en[0] == !$past(i_wr_data[2], 2))
        else $error("dcf");
    a_unmapped_zero: assert property (
        i_rd_en && i_addr == 8'h03 |=> o_rd_valid && o_rd_data == 8'h00)
        else $error("unmapped");
endmodule // ecc_bank_asserts

bind ecc_bank ecc_bank_asserts #(.N_CHAN(N_CHAN)) u_chk (.*);

// >>> dv/ecc_bank_tb.sv
// Self-checking bench for the control and status bank
// Assumes the bank design files and the checker are compiled first
module ecc_bank_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_ref_clk = 0, i_sys_rst = 1, i_wr_en = 0, i_rd_en = 0;
    logic [7:0] i_addr = 0, i_wr_data = 0, o_rd_data;
    logic [1:0] i_tone_seen = 0, i_phase_rev_seen = 0;
    logic [1:0] i_dtalk_seen = 0, i_nband_seen = 0;
    logic [1:0][7:0] i_far_end_in = 0, i_near_end_in = 0;
    logic [1:0][7:0] i_far_end_core = 0, i_near_end_core = 0;
    logic [1:0][7:0] o_far_end_out, o_near_end_out;
    logic [1:0] o_tone_det_en, o_phase_rev_need, o_nlp_en, o_nband_det_en;
    logic [1:0] o_dc_filter_en, o_bypass, o_coef_clear, o_adapt_halt;
    logic o_rd_valid, o_tone_pwr_down;
    logic [31:0] s = 32'h5887F188;
    logic [7:0] c [2];
    logic [7:0] e;
    logic [7:0] sv;
    int fails = 0, check_count = 0, cyc = 0;
    ecc_bank i_dut (.*);
    initial forever #20 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            print_verdict();
        end
    end
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] st(input int k);
        logic t;
        t = i_tone_seen[k] & ~c[k][7] & (c[k][6] | i_phase_rev_seen[k]);
        return {1'b0, t, i_dtalk_seen[k], 3'h0, c[k][4] & t,
            i_nband_seen[k] & ~c[k][3]};
    endfunction
    task automatic tick();
        @(posedge i_ref_clk);
        #1;
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] x);
        check_count++;
        if (g !== x) begin
            fails++;
            $display("wrong value t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic acc(input logic w, r, input logic [7:0] a, d);
        i_wr_en = w;
        i_rd_en = r;
        i_addr = a;
        i_wr_data = d;
        tick();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        acc(0, 1, a, 8'h00);
        cmp({7'h0, o_rd_valid}, 8'h01);
        cmp(o_rd_data, x);
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        c[0] = 8'h00;
        c[1] = 8'h00;
        repeat (16) tick();
        i_sys_rst = 0;
        foreach (c[k]) rd(8'(8'h01 + 8'h20 * k), 8'h00);
        for (int i = 0; i < 40; i++) begin
            s = nx(s);
            {i_tone_seen, i_phase_rev_seen, i_dtalk_seen, i_nband_seen} =
                s[7:0];
            {i_far_end_in, i_near_end_in} = nx(s);
            {i_far_end_core, i_near_end_core} = nx(nx(s));
            c[0] = s[15:8];
            c[1] = s[23:16];
            acc(1, 0, 8'h01, c[0]);
            acc(1, 0, 8'h21, c[1]);
            acc(1, 0, 8'h22, s[31:24]);
            acc(1, 0, 8'h40, s[31:24]);
            repeat (2) acc(0, 0, 8'h00, 8'h00);
            foreach (c[k]) begin
                sv = st(k);
                e = c[k][1] ? 8'hFF : sv[1] ? i_near_end_in[k]
                    : i_near_end_core[k];
                cmp(o_near_end_out[k], e);
                e = c[k][0] ? 8'hFF : sv[1] ? i_far_end_in[k]
                    : i_far_end_core[k];
                cmp(o_far_end_out[k], e);
                e = {~c[k][7:5], ~c[k][3:2], 3'h0};
                cmp({o_tone_det_en[k], o_phase_rev_need[k], o_nlp_en[k],
                    o_nband_det_en[k], o_dc_filter_en[k], 3'h0}, e);
                cmp({5'h0, o_bypass[k], o_coef_clear[k], o_adapt_halt[k]},
                    {5'h0, {3{sv[1]}}});
            end
            cmp({7'h0, o_tone_pwr_down}, {7'h0, c[0][7] & c[1][7]});
            rd(8'h02, st(0));
            rd(8'h22, st(1));
            rd(8'h01, c[0]);
            rd(8'h21, c[1]);
            rd(8'h03, 8'h00);
            acc(0, 0, 8'h00, 8'h00);
        end
        // Mid-run reset clears both registers again
        i_sys_rst = 1;
        repeat (2) acc(0, 0, 8'h00, 8'h00);
        i_sys_rst = 0;
        rd(8'h02, 8'h00);
        rd(8'h01, 8'h00);
        rd(8'h21, 8'h00);
        acc(0, 0, 8'h00, 8'h00);
        print_verdict();
    end
endmodule // ecc_bank_tb
